// File: design/dps_ctrl.sv
// device power-state controller: state machine, event flags, supply gating
// assumes all inputs synchronous to sys_clk; masks and option bits are
// driven by the system registers outside this block
`timescale 1ns/1ps
`include "dps_map.svh"

module dps_ctrl
   import dps_pkg::*;
#(
   parameter int RESUME_CYC = `DPS_RESUME_CYC,
   parameter int BOOT_CYC   = `DPS_BOOT_CYC
)
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   cmd_valid,
   input  wire dps_cmd_t               cmd_state,
   input  wire logic                   opt_adc,
   input  wire logic                   opt_tx,
   input  wire logic                   opt_tmr,
   input  wire logic                   opt_lf,
   input  wire logic [`DPS_FLAG_W-1:0] evt,
   input  wire logic [`DPS_FLAG_W-1:0] evt_mask,
   input  wire logic [`DPS_FLAG_W-1:0] flag_clr,
   input  wire logic [`DPS_ST_W-1:0]   stat_clr,
   input  wire logic                   samp_pwrup,
   input  wire logic                   tx_end,
   input  wire logic                   tx_rf_req,
   input  wire logic                   temp_hot,
   output dps_state_t                  state,
   output logic [`DPS_FLAG_W-1:0]      flags,
   output logic [`DPS_ST_W-1:0]        stat,
   output logic                        cpu_run,
   output logic                        cpu_clk_en,
   output logic                        boot_req,
   output logic                        resume_cont,
   output logic                        osc12_en,
   output logic                        osc90_en,
   output logic                        pwr_cpu,
   output logic                        pwr_sysctl,
   output logic                        pwr_adc,
   output logic                        pwr_tx,
   output logic                        pwr_rf,
   output logic                        pwr_tmr,
   output logic                        pwr_lf,
   output logic                        pwr_temp,
   output logic                        pwr_wuc
);

   localparam int CW = $clog2(RESUME_CYC + 1);

   // boot must fit inside the resume deadline
   if (BOOT_CYC < 1 || BOOT_CYC > RESUME_CYC) begin : g_chk
      $error("BOOT_CYC must lie in 1..RESUME_CYC");
   end

   // events that may end the given state
   function automatic logic [`DPS_FLAG_W-1:0] wake_ok(dps_state_t st);
      logic [`DPS_FLAG_W-1:0] m;
      m = '0;
      unique case (st)
         DPS_IDLE:  m = `DPS_WAKE_BITS | `DPS_RES_BITS;
         DPS_DIDLE: m = `DPS_WAKE_BITS;
         DPS_PDOWN: m = `DPS_WAKE_BITS;
         DPS_TXLP:  m = `DPS_ITIM_BIT;
         default:   m = '0;
      endcase
      return m;
   endfunction

   dps_state_t             state_q;
   dps_state_t             state_d;
   logic [`DPS_FLAG_W-1:0] flag_q;
   logic [`DPS_FLAG_W-1:0] flag_d;
   logic [`DPS_ST_W-1:0]   stat_q;
   logic [`DPS_ST_W-1:0]   stat_set;
   logic [CW-1:0]          cnt_q;
   logic                   opt_adc_q;
   logic                   opt_tx_q;
   logic                   opt_tmr_q;
   logic                   opt_lf_q;
   logic                   wake_hit;
   logic                   res_hit;
   logic                   boot_done;

   // resume-side registers lose supply in power-down and thermal shutdown,
   // and freeze in deep idle; in tx low power all but the ADC flag freeze
   always_comb begin
      flag_d = flag_q & ~flag_clr;
      flag_d = flag_d | (evt & `DPS_WAKE_BITS);
      unique case (state_q)
         DPS_PDOWN, DPS_TSD: begin
            flag_d = flag_d & `DPS_WAKE_BITS;
         end
         DPS_DIDLE: begin
            flag_d = (flag_d & `DPS_WAKE_BITS)
                   | (flag_q & `DPS_RES_BITS);
         end
         DPS_TXLP: begin
            flag_d = (flag_d & `DPS_WAKE_BITS)
                   | (flag_q & `DPS_RES_BITS)
                   | (evt & `DPS_ADC_BIT);
         end
         default: begin
            flag_d = flag_d | (evt & `DPS_RES_BITS);
         end
      endcase
   end

   // pending flags count as well, so a postponed event acts later
   assign wake_hit = |(flag_d & ~evt_mask & wake_ok(state_q));
   assign res_hit  = |(evt & ~evt_mask & `DPS_RES_BITS);
   assign boot_done = (cnt_q == CW'(BOOT_CYC - 1));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DPS_RUN: begin
            if (temp_hot) begin
               state_d = DPS_TSD;
            end else if (cmd_valid) begin
               unique case (cmd_state)
                  DPS_CMD_IDLE:  state_d = DPS_IDLE;
                  DPS_CMD_DIDLE: state_d = DPS_DIDLE;
                  DPS_CMD_PDOWN: state_d = DPS_PDOWN;
                  DPS_CMD_TXLP:  state_d = DPS_TXLP;
                  DPS_CMD_TSD:   state_d = DPS_TSD;
                  default:       state_d = DPS_RUN;
               endcase
            end
         end
         DPS_IDLE: begin
            if (wake_hit) begin
               state_d = DPS_RUN;
            end
         end
         DPS_DIDLE: begin
            if (wake_hit || samp_pwrup) begin
               state_d = DPS_BOOT;
            end
         end
         DPS_PDOWN: begin
            if (wake_hit) begin
               state_d = DPS_BOOT;
            end
         end
         DPS_TXLP: begin
            if (wake_hit || tx_end) begin
               state_d = DPS_BOOT;
            end
         end
         DPS_TSD: begin
            if (!temp_hot) begin
               state_d = DPS_BOOT;
            end
         end
         DPS_BOOT: begin
            if (boot_done) begin
               state_d = DPS_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= DPS_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   // firmware boot counter; restarts on every entry to boot
   always_ff @(posedge sys_clk) begin
      if (rst || state_q != DPS_BOOT) begin
         cnt_q <= '0;
      end else if (!boot_done) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // options are sampled only in run, so other states cannot change them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         opt_adc_q <= 1'b0;
         opt_tx_q  <= 1'b0;
         opt_tmr_q <= 1'b0;
         opt_lf_q  <= 1'b0;
      end else if (state_q == DPS_RUN) begin
         opt_adc_q <= opt_adc;
         opt_tx_q  <= opt_tx;
         opt_tmr_q <= opt_tmr;
         opt_lf_q  <= opt_lf;
      end
   end

   always_comb begin
      stat_set = '0;
      stat_set[`DPS_S_WUPDWN]  = (state_q == DPS_PDOWN) &&
                                 (state_d != DPS_PDOWN);
      stat_set[`DPS_S_TDET]    = (state_q == DPS_TSD) &&
                                 (state_d != DPS_TSD);
      stat_set[`DPS_S_REDIDLE] = (state_q == DPS_DIDLE) &&
                                 (state_d != DPS_DIDLE);
      stat_set[`DPS_S_RETXLP]  = (state_q == DPS_TXLP) &&
                                 (state_d != DPS_TXLP);
      stat_set[`DPS_S_WUPEND]  = |(evt & ~evt_mask & `DPS_WAKE_BITS)
                                 || (state_q == DPS_TSD && !temp_hot);
      stat_set[`DPS_S_REPEND]  = res_hit &&
                                 (state_q == DPS_RUN ||
                                  state_q == DPS_IDLE ||
                                  state_q == DPS_TXLP);
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         boot_req    <= 1'b0;
         resume_cont <= 1'b0;
      end else begin
         boot_req    <= (state_d == DPS_BOOT) &&
                        (state_q != DPS_BOOT);
         resume_cont <= (state_q == DPS_IDLE) &&
                        (state_d == DPS_RUN);
      end
   end

   // supply and clock gating follows the next state so it lines up with it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_run    <= 1'b0;
         cpu_clk_en <= 1'b0;
         osc12_en   <= 1'b0;
         osc90_en   <= 1'b0;
         pwr_cpu    <= 1'b0;
         pwr_sysctl <= 1'b0;
         pwr_adc    <= 1'b0;
         pwr_tx     <= 1'b0;
         pwr_rf     <= 1'b0;
         pwr_tmr    <= 1'b0;
         pwr_lf     <= 1'b0;
         pwr_temp   <= 1'b0;
         pwr_wuc    <= 1'b0;
      end else begin
         cpu_run    <= 1'b0;
         cpu_clk_en <= 1'b0;
         osc12_en   <= 1'b0;
         osc90_en   <= 1'b0;
         pwr_cpu    <= 1'b0;
         pwr_sysctl <= 1'b0;
         pwr_adc    <= 1'b0;
         pwr_tx     <= 1'b0;
         pwr_rf     <= 1'b0;
         pwr_tmr    <= 1'b0;
         pwr_lf     <= 1'b0;
         pwr_temp   <= 1'b0;
         pwr_wuc    <= 1'b1; // always-on 2.2 kHz domain
         unique case (state_d)
            DPS_RUN: begin
               cpu_run    <= 1'b1;
               cpu_clk_en <= 1'b1;
               osc12_en   <= 1'b1;
               osc90_en   <= opt_lf_q;
               pwr_cpu    <= 1'b1;
               pwr_sysctl <= 1'b1;
               pwr_adc    <= opt_adc_q;
               pwr_tx     <= opt_tx_q;
               pwr_rf     <= opt_tx_q;
               pwr_tmr    <= opt_tmr_q;
               pwr_lf     <= opt_lf_q;
               pwr_temp   <= 1'b1;
            end
            DPS_IDLE: begin
               cpu_clk_en <= 1'b1;
               osc12_en   <= 1'b1;
               osc90_en   <= opt_lf_q;
               pwr_cpu    <= 1'b1;
               pwr_sysctl <= 1'b1;
               pwr_adc    <= opt_adc_q;
               pwr_tx     <= opt_tx_q;
               pwr_rf     <= opt_tx_q;
               pwr_tmr    <= opt_tmr_q;
               pwr_lf     <= opt_lf_q;
            end
            DPS_DIDLE: begin
               osc90_en   <= 1'b1;
               pwr_sysctl <= 1'b1;
               pwr_lf     <= opt_lf_q;
            end
            DPS_PDOWN: begin
               osc90_en   <= opt_lf_q;
               pwr_lf     <= opt_lf_q;
            end
            DPS_TXLP: begin
               osc90_en   <= 1'b1;
               pwr_tx     <= 1'b1;
               pwr_rf     <= tx_rf_req;
               pwr_lf     <= opt_lf_q;
            end
            DPS_TSD: begin
               pwr_temp   <= 1'b1;
            end
            DPS_BOOT: begin
               cpu_clk_en <= 1'b1;
               osc12_en   <= 1'b1;
               pwr_cpu    <= 1'b1;
               pwr_sysctl <= 1'b1;
            end
         endcase
      end
   end

   assign state = state_q;
   assign flags = flag_q;
   assign stat  = stat_q;

endmodule

// File: design/dps_map.svh
// constants of the device power-state controller
// assumes a 100 MHz sys_clk and event inputs synchronous to it
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

`define DPS_CLK_MHZ        100
`define DPS_T_RESUME_US    750
`define DPS_RESUME_CYC     (`DPS_T_RESUME_US * `DPS_CLK_MHZ)
`define DPS_BOOT_CYC       1000

`define DPS_FLAG_W         14
`define DPS_WAKE_W         8
`define DPS_F_ITIM         0
`define DPS_F_EXT          1
`define DPS_F_CD           2
`define DPS_F_SYNC         3
`define DPS_F_PM0          4
`define DPS_F_PM1          5
`define DPS_F_EOM          6
`define DPS_F_BF           7
`define DPS_F_TMR0         8
`define DPS_F_TMR1         9
`define DPS_F_TXBE         10
`define DPS_F_TXSE         11
`define DPS_F_ADC          12
`define DPS_F_SAMP         13

`define DPS_WAKE_BITS      14'h00ff
`define DPS_RES_BITS       14'h3f00
`define DPS_ITIM_BIT       14'h0001
`define DPS_ADC_BIT        14'h1000

`define DPS_ST_W           6
`define DPS_S_WUPDWN       0
`define DPS_S_TDET         1
`define DPS_S_REDIDLE      2
`define DPS_S_RETXLP       3
`define DPS_S_WUPEND       4
`define DPS_S_REPEND       5

`endif

// File: design/dps_pkg.sv
// types of the device power-state controller
// constants live in dps_map.svh
package dps_pkg;

   typedef enum logic [6:0] {
      DPS_RUN   = 7'h01,
      DPS_IDLE  = 7'h02,
      DPS_DIDLE = 7'h04,
      DPS_PDOWN = 7'h08,
      DPS_TXLP  = 7'h10,
      DPS_TSD   = 7'h20,
      DPS_BOOT  = 7'h40
   } dps_state_t;

   typedef enum logic [2:0] {
      DPS_CMD_IDLE  = 3'h0,
      DPS_CMD_DIDLE = 3'h1,
      DPS_CMD_PDOWN = 3'h2,
      DPS_CMD_TXLP  = 3'h3,
      DPS_CMD_TSD   = 3'h4
   } dps_cmd_t;

endpackage

// File: verif/dps_ctrl_sva.sv
// checker for dps_ctrl: state entry, power levels and exit timing
// assumes a bind to dps_ctrl; everything sampled on sys_clk rising edge
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_ctrl_sva
   import dps_pkg::*;
#(
   parameter int RESUME_CYC = 20,
   parameter int BOOT_CYC   = 4
)
(
   input wire logic                   sys_clk,
   input wire logic                   rst,
   input wire logic                   cmd_valid,
   input wire dps_cmd_t               cmd_state,
   input wire logic [`DPS_FLAG_W-1:0] evt,
   input wire logic [`DPS_FLAG_W-1:0] evt_mask,
   input wire logic                   tx_end,
   input wire logic                   temp_hot,
   input wire dps_state_t             state,
   input wire logic [`DPS_FLAG_W-1:0] flags,
   input wire logic                   cpu_run,
   input wire logic                   cpu_clk_en,
   input wire logic                   boot_req,
   input wire logic                   resume_cont,
   input wire logic                   osc12_en,
   input wire logic                   osc90_en,
   input wire logic                   pwr_cpu,
   input wire logic                   pwr_sysctl,
   input wire logic                   pwr_rf,
   input wire logic                   pwr_temp,
   input wire logic                   pwr_wuc
);
   logic [31:0]            boot_cnt_q;
   logic [`DPS_FLAG_W-1:0] wake_now;
   assign wake_now = (evt | flags) & ~evt_mask;
   // cycles spent in boot so far; cleared whenever boot is left
   always_ff @(posedge sys_clk) begin
      if (rst || state != DPS_BOOT) begin
         boot_cnt_q <= 32'h0;
      end else begin
         boot_cnt_q <= boot_cnt_q + 32'h1;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_idle_exit;
      state == DPS_IDLE ##1 state == DPS_RUN;
   endsequence
   sequence s_boot_last;
      state == DPS_BOOT && boot_cnt_q == BOOT_CYC - 1 && BOOT_CYC <= RESUME_CYC;
   endsequence
   a_idle_cmd_taken: assert property (
      state == DPS_RUN && !temp_hot && cmd_valid && cmd_state == DPS_CMD_IDLE
      |=> state == DPS_IDLE) else $error("idle command lost");
   a_idle_cpu_halt: assert property (
      state == DPS_IDLE |-> !cpu_run && cpu_clk_en && osc12_en && pwr_cpu)
      else $error("idle power wrong");
   a_idle_resume: assert property (s_idle_exit |-> resume_cont)
      else $error("no continue pulse");
   a_didle_power: assert property (
      state == DPS_DIDLE |-> !pwr_cpu && osc90_en && pwr_sysctl && pwr_wuc)
      else $error("deep idle power wrong");
   a_pdown_power: assert property (
      state == DPS_PDOWN |-> !pwr_cpu && !osc12_en && !pwr_sysctl && pwr_wuc)
      else $error("power-down power wrong");
   a_pdown_hold: assert property (
      state == DPS_PDOWN && (wake_now & `DPS_WAKE_BITS) == 14'h0000
      |=> state == DPS_PDOWN) else $error("power-down left early");
   a_txlp_hold: assert property (
      state == DPS_TXLP && !tx_end && !wake_now[`DPS_F_ITIM]
      |=> state == DPS_TXLP) else $error("tx low power left early");
   a_txlp_exit: assert property (
      state == DPS_TXLP && tx_end |=> state == DPS_BOOT && boot_req)
      else $error("tx end ignored");
   a_tsd_power: assert property (
      state == DPS_TSD |-> pwr_temp && pwr_wuc && !pwr_cpu && !osc90_en)
      else $error("shutdown power wrong");
   a_tsd_hold: assert property (state == DPS_TSD && temp_hot |=>
      state == DPS_TSD) else $error("shutdown left while hot");
   a_boot_hold: assert property (
      state == DPS_BOOT && boot_cnt_q < BOOT_CYC - 1 |=> state == DPS_BOOT)
      else $error("boot cut short");
   a_boot_done: assert property (s_boot_last |=> state == DPS_RUN
      && cpu_run) else $error("boot overran");
   a_flag_any_mask: assert property (evt[`DPS_F_EXT] |=>
      flags[`DPS_F_EXT]) else $error("flag not set");
endmodule

// File: verif/dps_ctrl_tb_top.sv
// bench for dps_ctrl: enters each idle, power-down, tx low power and shutdown state from run and checks its exit
// assumes dps_pkg compiled first, dps_map.svh on the include path
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_ctrl_tb_top
   import dps_pkg::*;
;
   localparam int BOOT_N = 4;
   localparam int RES_N  = 20;
   logic sys_clk, rst, cmd_valid, opt_adc, opt_tx, opt_tmr, opt_lf;
   logic samp_pwrup, tx_end, tx_rf_req, temp_hot, cpu_run, cpu_clk_en;
   logic boot_req, resume_cont, osc12_en, osc90_en, pwr_cpu, pwr_sysctl;
   logic pwr_adc, pwr_tx, pwr_rf, pwr_tmr, pwr_lf, pwr_temp, pwr_wuc;
   dps_cmd_t               cmd_state;
   dps_state_t             state;
   logic [`DPS_FLAG_W-1:0] evt, evt_mask, flag_clr, flags;
   logic [`DPS_ST_W-1:0]   stat_clr, stat;
   int                     err_count, total_checks;

   dps_ctrl #(.RESUME_CYC(RES_N), .BOOT_CYC(BOOT_N)) dps_ctrl_inst (
      .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_state(cmd_state), .opt_adc(opt_adc), .opt_tx(opt_tx),
      .opt_tmr(opt_tmr), .opt_lf(opt_lf), .evt(evt), .evt_mask(evt_mask),
      .flag_clr(flag_clr), .stat_clr(stat_clr), .samp_pwrup(samp_pwrup),
      .tx_end(tx_end), .tx_rf_req(tx_rf_req), .temp_hot(temp_hot),
      .state(state), .flags(flags), .stat(stat), .cpu_run(cpu_run),
      .cpu_clk_en(cpu_clk_en), .boot_req(boot_req),
      .resume_cont(resume_cont), .osc12_en(osc12_en), .osc90_en(osc90_en),
      .pwr_cpu(pwr_cpu), .pwr_sysctl(pwr_sysctl), .pwr_adc(pwr_adc),
      .pwr_tx(pwr_tx), .pwr_rf(pwr_rf), .pwr_tmr(pwr_tmr), .pwr_lf(pwr_lf),
      .pwr_temp(pwr_temp), .pwr_wuc(pwr_wuc));

   always #5 sys_clk = ~sys_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic check_st(input dps_state_t s);
      check(16'(state), 16'(s));
   endtask
   task automatic cmd(input dps_cmd_t c);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_state <= c;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic fire(input logic [13:0] e, input logic s, input logic t);
      @(posedge sys_clk);
      evt        <= e;
      samp_pwrup <= s;
      tx_end     <= t;
      @(posedge sys_clk);
      evt        <= '0;
      samp_pwrup <= 1'b0;
      tx_end     <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic clr_all(input logic [13:0] m);
      @(posedge sys_clk);
      flag_clr <= '1;
      stat_clr <= '1;
      @(posedge sys_clk);
      flag_clr <= '0;
      stat_clr <= '0;
      evt_mask <= m;
   endtask
   // called at the negedge just after the waking edge
   task automatic boot_wait(input logic [5:0] st_exp);
      int n;
      n = 0;
      check(16'(boot_req), 16'h0001);
      check(16'(stat), 16'(st_exp));
      while (state !== DPS_RUN && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      check(16'(n), 16'(BOOT_N));
   endtask

   task automatic t_run;
      check_st(DPS_RUN);
      check(16'({cpu_run, cpu_clk_en, osc12_en, pwr_adc}), 16'h000e);
      cmd(dps_cmd_t'(3'h5));
      check_st(DPS_RUN);
   endtask
   task automatic t_idle;
      @(posedge sys_clk);
      opt_adc <= 1'b1;
      opt_lf  <= 1'b1;
      opt_tmr <= 1'b1;
      cmd(DPS_CMD_IDLE);
      check(16'({cpu_run, osc12_en, pwr_adc, pwr_lf, pwr_tx, pwr_tmr}),
            16'h001d);
      fire(14'h0100, 1'b0, 1'b0);
      check(16'(flags), 16'h0100);
      cmd(DPS_CMD_PDOWN);
      check_st(DPS_IDLE);
      @(posedge sys_clk);
      evt_mask <= 14'h3eff;
      @(posedge sys_clk);
      opt_adc <= 1'b0;
      opt_lf  <= 1'b0;
      opt_tmr <= 1'b0;
      @(negedge sys_clk);
      check(16'({state == DPS_RUN, resume_cont}), 16'h0003);
      clr_all('1);
   endtask
   task automatic t_didle;
      cmd(DPS_CMD_DIDLE);
      check(16'({pwr_cpu, osc90_en, pwr_sysctl, pwr_wuc}), 16'h0007);
      fire(14'h0002, 1'b0, 1'b0);
      check_st(DPS_DIDLE);
      fire(14'h0000, 1'b1, 1'b0);
      boot_wait(6'h04);
      clr_all(14'h00fe);
   endtask
   task automatic t_pdown;
      cmd(DPS_CMD_PDOWN);
      check(16'({pwr_cpu, osc12_en, osc90_en, pwr_wuc}), 16'h0001);
      fire(14'h0100, 1'b0, 1'b0);
      check(16'({state == DPS_PDOWN, flags}), 16'h4000);
      fire(14'h0001, 1'b0, 1'b0);
      boot_wait(6'h11);
      clr_all(14'h0000);
   endtask
   task automatic t_txlp;
      cmd(DPS_CMD_TXLP);
      check(16'({osc90_en, pwr_tx, pwr_rf, pwr_cpu}), 16'h000c);
      @(posedge sys_clk);
      tx_rf_req <= 1'b1;
      fire(14'h0004, 1'b0, 1'b0);
      check(16'({pwr_rf, state == DPS_TXLP, flags}), 16'hc004);
      fire(14'h0000, 1'b0, 1'b1);
      boot_wait(6'h18);
      @(posedge sys_clk);
      tx_rf_req <= 1'b0;
      cmd(DPS_CMD_PDOWN);
      @(negedge sys_clk);
      check_st(DPS_BOOT);
      repeat (BOOT_N + 1) @(negedge sys_clk);
      clr_all(14'h0000);
   endtask
   task automatic t_tsd;
      @(posedge sys_clk);
      temp_hot <= 1'b1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check(16'({state == DPS_TSD, pwr_temp, pwr_wuc, pwr_cpu}), 16'h000e);
      fire(14'h0001, 1'b0, 1'b0);
      check_st(DPS_TSD);
      @(posedge sys_clk);
      temp_hot <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      boot_wait(6'h12);
      clr_all(14'h0000);
      cmd(DPS_CMD_TSD);
      check_st(DPS_TSD);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      {sys_clk, cmd_valid, opt_adc, opt_tx, opt_tmr, opt_lf} = '0;
      {samp_pwrup, tx_end, tx_rf_req, temp_hot} = '0;
      {evt, flag_clr, stat_clr} = '0;
      cmd_state = DPS_CMD_IDLE;
      evt_mask = '1;
      rst = 1'b1;
      err_count = 0;
      total_checks = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      t_run;
      t_idle;
      t_didle;
      t_pdown;
      t_txlp;
      t_tsd;
      stop_test;
   end

   // the whole sequence needs under a hundred cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      stop_test;
   end
endmodule

bind dps_ctrl dps_ctrl_sva #(.RESUME_CYC(RESUME_CYC), .BOOT_CYC(BOOT_CYC))
   dps_ctrl_sva_inst (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
   .cmd_state(cmd_state), .evt(evt), .evt_mask(evt_mask), .tx_end(tx_end),
   .temp_hot(temp_hot), .state(state), .flags(flags), .cpu_run(cpu_run),
   .cpu_clk_en(cpu_clk_en), .boot_req(boot_req), .resume_cont(resume_cont),
   .osc12_en(osc12_en), .osc90_en(osc90_en), .pwr_cpu(pwr_cpu),
   .pwr_sysctl(pwr_sysctl), .pwr_rf(pwr_rf), .pwr_temp(pwr_temp),
   .pwr_wuc(pwr_wuc));
